/* File: uart_lin_pkg.sv */
// Shared constants, types and decoders for both line ends.
package uart_lin_pkg;

   // ----------------------------------------------------------------
   // Device control word bit positions.
   // ----------------------------------------------------------------
   localparam int unsigned CTL_AUTOBAUD_ARM = 0;
   localparam int unsigned CTL_WAKE_ARM     = 1;
   localparam int unsigned CTL_FAST_RATE    = 2;
   localparam int unsigned CTL_WIDE_DIVIDER = 3;
   localparam int unsigned CTL_BREAK_SEND   = 4;
   localparam int unsigned CTL_TX_ENABLE    = 5;
   localparam int unsigned CTL_OVERFLOW     = 6;
   localparam int unsigned CTL_RX_IDLE      = 7;

   // ----------------------------------------------------------------
   // Reset values and character lengths.
   // ----------------------------------------------------------------
   localparam logic [15:0] DIVISOR_RST   = 16'h0000;
   localparam logic [3:0]  CHAR_BITS     = 4'hA;    // Start, eight data, stop.
   localparam logic [3:0]  BREAK_BITS    = 4'hE;    // Start, twelve zeros, stop.
   localparam logic [3:0]  NODE_BRK_BITS = 4'hE;    // Thirteen low bits, stop.
   localparam logic [2:0]  SYNC_RISES    = 3'h5;    // Rising edges of a 55h sync character.
   localparam logic [15:0] COUNT_FIRST   = 16'h0001;
   localparam int unsigned CAL_PRESCALE  = 8;       // Base clock over eight.

   // ----------------------------------------------------------------
   // Controller register map on AXI4-Lite.
   // ----------------------------------------------------------------
   localparam logic [7:0]  REG_BIT_LEN   = 8'h00;
   localparam logic [7:0]  REG_TX_CMD    = 8'h04;
   localparam logic [7:0]  REG_STATUS    = 8'h08;
   localparam logic [15:0] BIT_LEN_RST   = 16'h0064;
   localparam int unsigned CMD_BREAK     = 8;
   localparam logic [1:0]  RESP_OKAY     = 2'h0;
   localparam logic [1:0]  RESP_SLVERR   = 2'h2;

   // ----------------------------------------------------------------
   // Calibration state machine.
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      CAL_IDLE  = 4'h1,
      CAL_START = 4'h2,
      CAL_FIRST = 4'h4,
      CAL_COUNT = 4'h8
   } cal_state_t;

   // Base clock divide in oscillator cycles for the select pair.
   function automatic logic [6:0] base_div(input logic wide, input logic fast);
      case ({wide, fast})
         2'b00:   base_div = 7'h40;
         2'b01:   base_div = 7'h10;
         2'b10:   base_div = 7'h10;
         default: base_div = 7'h04;
      endcase
   endfunction

   // Last prescaler count of a calibration tick.
   function automatic logic [9:0] cal_last(input logic wide, input logic fast);
      cal_last = 10'(32'(base_div(wide, fast)) * CAL_PRESCALE - 1);
   endfunction

endpackage

/* File: uart_lin_if.sv */
// Serial line between the serial port and the remote node.
`timescale 1ns/1ns
interface uart_lin_if;
   logic serial_in_line;   // Remote node to device, idles high.
   logic serial_out_line;  // Device to remote node, idles high.
   modport dev_mp  (input serial_in_line, output serial_out_line);
   modport node_mp (output serial_in_line, input serial_out_line);
endinterface

/* File: uart_lin_dev.sv */
// Serial port end: rate calibration, wake and break send.
//
// The implementer's own choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ns
// Contract
// - Arm starts calibration, receiver held idle.
// - Calibration times a 55h sync character.
// - Count first to fifth rise; store, disarm, flag.
// - Software reads buffer; read clears receive flag.
// - Both divisor bytes form one 16-bit counter.
// - Counter ticks at base clock over eight.
// - Calibration count starts at one.
// - With wake armed, calibrate byte after break.
// - Overflow sets flag bits, counting continues.
// - Receive idle reads zero until fifth rise.
// - Fifth rise sets flag again after read.
// - Early disarm leaves later falls as starts.
// - Software clears overflow after idle returns.
// - Wake arm suspends reception, watches falling edge.
// - Wake event sets flag; buffer read clears.
// - Break-ending rise clears wake arm.
// - Remote wake character is long all zeros.
// - Software checks idle before arming wake.
// - Break is start, twelve zeros, stop.
// - Break-send write sends zeros, ignores data.
// - Break-send clears after stop; queued byte follows.
// - Shift-empty shows activity during break too.
module uart_lin_dev (
   // Clock and reset.
   input  wire logic        i_ref_clk,
   input  wire logic        i_resetn,
   // Control word write and status.
   input  wire logic        i_ctl_wr,
   input  wire logic [7:0]  i_ctl_wdata,
   output logic      [7:0]  o_ctl_status,
   // Divisor pair.
   input  wire logic        i_div_wr,
   input  wire logic [15:0] i_div_wdata,
   output logic      [15:0] o_divisor,
   // Receive buffer read and flag.
   input  wire logic        i_rxbuf_rd,
   output logic             o_receive_flag,
   // Transmit buffer and status.
   input  wire logic        i_txbuf_wr,
   input  wire logic [7:0]  i_txbuf_wdata,
   output logic             o_transmit_flag,
   output logic             o_shift_empty,
   // Serial line.
   uart_lin_if.dev_mp       line
);

   // ----------------------------------------------------------------
   // State.
   // ----------------------------------------------------------------
   typedef struct packed {
      uart_lin_pkg::cal_state_t cal;
      logic        autobaud_arm;
      logic        wake_arm;
      logic        wake_fell;
      logic        fast_rate_select;
      logic        wide_divider_select;
      logic        break_send;
      logic        transmit_enable;
      logic        calibration_overflow;
      logic        receive_flag;
      logic        receive_idle_status;
      logic [15:0] divisor;
      logic [9:0]  cal_pre;
      logic [2:0]  rises;
      logic        line_prev;
      logic [6:0]  base_cnt;
      logic [15:0] rate_cnt;
      logic        tx_pend;
      logic        tx_pend_brk;
      logic [7:0]  tx_hold;
      logic [13:0] shreg;
      logic [3:0]  bits_left;
      logic        tx_busy;
      logic        tx_brk;
      logic        tx_line;
   } dev_state_t;

   dev_state_t q;
   dev_state_t d;

   localparam dev_state_t DEV_RST = '{
      cal: uart_lin_pkg::CAL_IDLE, receive_idle_status: 1'b1, divisor: uart_lin_pkg::DIVISOR_RST,
      line_prev: 1'b1, tx_line: 1'b1, default: '0};

   // ----------------------------------------------------------------
   // Next-state logic.
   // ----------------------------------------------------------------
   // Events follow software writes, so a hardware set beats a same-cycle clear.
   always_comb begin
      logic rise;
      logic fall;
      logic [15:0] div_eff;
      logic tick;
      rise = 1'b0;
      fall = 1'b0;
      div_eff = '0;
      tick = 1'b0;
      d = q;
      rise = line.serial_in_line & ~q.line_prev;
      fall = ~line.serial_in_line & q.line_prev;
      d.line_prev = line.serial_in_line;

      // Control word write; software can only clear overflow.
      if (i_ctl_wr) begin
         d.autobaud_arm        = i_ctl_wdata[uart_lin_pkg::CTL_AUTOBAUD_ARM];
         d.wake_arm            = i_ctl_wdata[uart_lin_pkg::CTL_WAKE_ARM];
         d.fast_rate_select    = i_ctl_wdata[uart_lin_pkg::CTL_FAST_RATE];
         d.wide_divider_select = i_ctl_wdata[uart_lin_pkg::CTL_WIDE_DIVIDER];
         d.break_send          = i_ctl_wdata[uart_lin_pkg::CTL_BREAK_SEND];
         d.transmit_enable     = i_ctl_wdata[uart_lin_pkg::CTL_TX_ENABLE];
         d.calibration_overflow = q.calibration_overflow & i_ctl_wdata[uart_lin_pkg::CTL_OVERFLOW];
      end
      // Calibration owns the divisor pair while it runs.
      if (i_div_wr && q.cal == uart_lin_pkg::CAL_IDLE) begin
         d.divisor = i_div_wdata;
      end
      // No data is kept; a read only clears the flag.
      if (i_rxbuf_rd) begin
         d.receive_flag = 1'b0;
      end

      // Rate calibration sequence.
      case (q.cal)
         uart_lin_pkg::CAL_IDLE: begin
            if (q.autobaud_arm) begin
               d.cal = uart_lin_pkg::CAL_START;
            end
         end
         uart_lin_pkg::CAL_START: begin
            // With wake armed the break goes first; the next start is the sync.
            if (!q.wake_arm && fall) begin
               d.cal = uart_lin_pkg::CAL_FIRST;
            end
         end
         uart_lin_pkg::CAL_FIRST: begin
            if (rise) begin
               d.cal     = uart_lin_pkg::CAL_COUNT;
               d.divisor = uart_lin_pkg::COUNT_FIRST;
               d.cal_pre = '0;
               d.rises   = 3'h1;
            end
         end
         uart_lin_pkg::CAL_COUNT: begin
            d.cal_pre = q.cal_pre + 10'h001;
            if (q.cal_pre == uart_lin_pkg::cal_last(q.wide_divider_select, q.fast_rate_select)) begin
               d.cal_pre = '0;
               d.divisor = q.divisor + 16'h0001;
               if (q.divisor == 16'hFFFF) begin
                  d.calibration_overflow = 1'b1;
                  d.receive_flag         = 1'b1;
               end
            end
            if (rise) begin
               d.rises = q.rises + 3'h1;
               if (q.rises == uart_lin_pkg::SYNC_RISES - 3'h1) begin
                  d.cal          = uart_lin_pkg::CAL_IDLE;
                  d.autobaud_arm = 1'b0;
                  d.receive_flag = 1'b1;
               end
            end
         end
         default: begin
            d.cal = uart_lin_pkg::CAL_IDLE;
         end
      endcase
      // Disarming abandons the sequence; later falls count as starts.
      if (!d.autobaud_arm) begin
         d.cal = uart_lin_pkg::CAL_IDLE;
      end
      d.receive_idle_status = (d.cal == uart_lin_pkg::CAL_IDLE) && !d.wake_arm;

      // Wake on break: watched every clock, so any processor state sees it.
      if (!q.wake_arm) begin
         d.wake_fell = 1'b0;
      end else begin
         if (fall) begin
            d.receive_flag = 1'b1;
            d.wake_fell    = 1'b1;
         end
         if (rise && q.wake_fell) begin
            d.wake_arm  = 1'b0;
            d.wake_fell = 1'b0;
         end
      end

      // A write with break-send set and no break running queues a break.
      if (i_txbuf_wr && q.transmit_enable && !q.tx_pend) begin
         d.tx_pend     = 1'b1;
         d.tx_hold     = i_txbuf_wdata;
         d.tx_pend_brk = q.break_send && !q.tx_brk;
      end

      // Rate generator and shifter; narrow mode uses the low divisor byte only.
      div_eff = q.wide_divider_select ? q.divisor : {8'h00, q.divisor[7:0]};
      if (q.tx_busy) begin
         d.base_cnt = q.base_cnt + 7'h01;
         if (q.base_cnt == uart_lin_pkg::base_div(q.wide_divider_select, q.fast_rate_select) - 7'h01) begin
            d.base_cnt = '0;
            d.rate_cnt = q.rate_cnt + 16'h0001;
            if (q.rate_cnt == div_eff) begin
               d.rate_cnt = '0;
               tick       = 1'b1;
            end
         end
         if (tick) begin
            d.shreg     = {1'b1, q.shreg[13:1]};
            d.bits_left = q.bits_left - 4'h1;
            if (q.bits_left == 4'h1) begin
               d.tx_busy = 1'b0;
               if (q.tx_brk) begin
                  d.break_send = 1'b0;
                  d.tx_brk     = 1'b0;
               end
            end
         end
      end else if (q.tx_pend) begin
         // Loading right after the stop bit lets a queued byte follow a break at once.
         d.tx_pend   = 1'b0;
         d.tx_busy   = 1'b1;
         d.tx_brk    = q.tx_pend_brk;
         d.base_cnt  = '0;
         d.rate_cnt  = '0;
         d.shreg     = q.tx_pend_brk ? {1'b1, 13'h0000} : {5'h1F, q.tx_hold, 1'b0};
         d.bits_left = q.tx_pend_brk ? uart_lin_pkg::BREAK_BITS : uart_lin_pkg::CHAR_BITS;
      end
      // Dropping transmit-enable abandons all transmit work.
      if (!d.transmit_enable) begin
         d.tx_busy = 1'b0;
         d.tx_pend = 1'b0;
         d.tx_brk  = 1'b0;
      end
      d.tx_line = d.tx_busy ? d.shreg[0] : 1'b1;
   end

   // ----------------------------------------------------------------
   // State register.
   // ----------------------------------------------------------------
   // One register stage keeps outputs glitch-free, one cycle behind their cause.
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         q <= DEV_RST;
      end else begin
         q <= d;
      end
   end

   // ----------------------------------------------------------------
   // Registered outputs.
   // ----------------------------------------------------------------
   // Status mirrors control plus overflow and receive idle.
   assign o_ctl_status = {q.receive_idle_status, q.calibration_overflow, q.transmit_enable, q.break_send,
                          q.wide_divider_select, q.fast_rate_select, q.wake_arm, q.autobaud_arm};
   assign o_divisor            = q.divisor;
   assign o_receive_flag       = q.receive_flag;
   assign o_transmit_flag      = ~q.tx_pend;
   assign o_shift_empty        = ~q.tx_busy;
   assign line.serial_out_line = q.tx_line;

endmodule

/* File: uart_lin_node.sv */
// Remote node end: AXI4-Lite driven break and character sender.
`timescale 1ns/1ns
module uart_lin_node (
   // Clock and reset.
   input  wire logic        i_ref_clk,
   input  wire logic        i_resetn,
   // AXI4-Lite write channels.
   input  wire logic [7:0]  i_awaddr,
   input  wire logic        i_awvalid,
   output logic             o_awready,
   input  wire logic [31:0] i_wdata,
   input  wire logic [3:0]  i_wstrb,
   input  wire logic        i_wvalid,
   output logic             o_wready,
   output logic [1:0]       o_bresp,
   output logic             o_bvalid,
   input  wire logic        i_bready,
   // AXI4-Lite read channels.
   input  wire logic [7:0]  i_araddr,
   input  wire logic        i_arvalid,
   output logic             o_arready,
   output logic [31:0]      o_rdata,
   output logic [1:0]       o_rresp,
   output logic             o_rvalid,
   input  wire logic        i_rready,
   // Serial line.
   uart_lin_if.node_mp      line
);

   // ----------------------------------------------------------------
   // State.
   // ----------------------------------------------------------------
   typedef struct packed {
      logic        aw_rdy;
      logic        w_rdy;
      logic        aw_got;
      logic        w_got;
      logic [7:0]  waddr;
      logic [31:0] wdata;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        ar_rdy;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
      logic [15:0] bit_len;
      logic        pend;
      logic [8:0]  pend_cmd;
      logic        busy;
      logic [13:0] sh;
      logic [3:0]  left;
      logic [15:0] cnt;
      logic        line_out;
   } node_state_t;

   node_state_t q;
   node_state_t d;

   localparam node_state_t NODE_RST = '{
      aw_rdy: 1'b1, w_rdy: 1'b1, ar_rdy: 1'b1, bit_len: uart_lin_pkg::BIT_LEN_RST, line_out: 1'b1, default: '0};

   // ----------------------------------------------------------------
   // Next-state logic.
   // ----------------------------------------------------------------
   // Address and data come in either order; the write acts once both are held.
   always_comb begin
      d = q;
      if (i_awvalid && q.aw_rdy) begin
         d.aw_got = 1'b1;
         d.waddr  = i_awaddr;
      end
      if (i_wvalid && q.w_rdy) begin
         d.w_got = 1'b1;
         d.wdata = i_wdata;
      end
      if (q.bvalid && i_bready) begin
         d.bvalid = 1'b0;
      end
      if (q.aw_got && q.w_got && !q.bvalid) begin
         d.aw_got = 1'b0;
         d.w_got  = 1'b0;
         d.bvalid = 1'b1;
         d.bresp  = uart_lin_pkg::RESP_OKAY;
         case (q.waddr)
            uart_lin_pkg::REG_BIT_LEN: begin
               if (q.wdata[15:0] != 16'h0000) begin
                  d.bit_len = q.wdata[15:0];
               end
            end
            uart_lin_pkg::REG_TX_CMD: begin
               // A command while one waits is dropped; software polls pending first.
               if (!q.pend) begin
                  d.pend     = 1'b1;
                  d.pend_cmd = q.wdata[8:0];
               end
            end
            uart_lin_pkg::REG_STATUS: begin
               d.bresp = uart_lin_pkg::RESP_OKAY;
            end
            default: begin
               d.bresp = uart_lin_pkg::RESP_SLVERR;
            end
         endcase
      end
      d.aw_rdy = !d.aw_got;
      d.w_rdy  = !d.w_got;

      // Read channel: one read answered at a time.
      if (q.rvalid && i_rready) begin
         d.rvalid = 1'b0;
      end
      if (i_arvalid && q.ar_rdy) begin
         d.rvalid = 1'b1;
         d.rresp  = uart_lin_pkg::RESP_OKAY;
         d.rdata  = '0;
         case (i_araddr)
            uart_lin_pkg::REG_BIT_LEN: d.rdata = {16'h0000, q.bit_len};
            uart_lin_pkg::REG_TX_CMD:  d.rdata = {23'h000000, q.pend_cmd};
            uart_lin_pkg::REG_STATUS:  d.rdata = {29'h00000000, line.serial_out_line, q.pend, q.busy};
            default:                   d.rresp = uart_lin_pkg::RESP_SLVERR;
         endcase
      end
      d.ar_rdy = !d.rvalid;

      // Serial sender; a break is thirteen low bit times so a waking device sees it.
      if (q.busy) begin
         d.cnt = q.cnt + 16'h0001;
         if (q.cnt == q.bit_len - 16'h0001) begin
            d.cnt  = '0;
            d.sh   = {1'b1, q.sh[13:1]};
            d.left = q.left - 4'h1;
            if (q.left == 4'h1) begin
               d.busy = 1'b0;
            end
         end
      end else if (q.pend) begin
         d.pend = 1'b0;
         d.busy = 1'b1;
         d.cnt  = '0;
         if (q.pend_cmd[uart_lin_pkg::CMD_BREAK]) begin
            d.sh   = {1'b1, 13'h0000};
            d.left = uart_lin_pkg::NODE_BRK_BITS;
         end else begin
            d.sh   = {5'h1F, q.pend_cmd[7:0], 1'b0};
            d.left = uart_lin_pkg::CHAR_BITS;
         end
      end
      d.line_out = d.busy ? d.sh[0] : 1'b1;
   end

   // ----------------------------------------------------------------
   // State register.
   // ----------------------------------------------------------------
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         q <= NODE_RST;
      end else begin
         q <= d;
      end
   end

   // ----------------------------------------------------------------
   // Registered outputs.
   // ----------------------------------------------------------------
   assign o_awready           = q.aw_rdy;
   assign o_wready            = q.w_rdy;
   assign o_bvalid            = q.bvalid;
   assign o_bresp             = q.bresp;
   assign o_arready           = q.ar_rdy;
   assign o_rvalid            = q.rvalid;
   assign o_rdata             = q.rdata;
   assign o_rresp             = q.rresp;
   assign line.serial_in_line = q.line_out;

endmodule

/* File: uart_lin_properties.sv */
// Concurrent checks on the line and device status.
`timescale 1ns/1ns
module uart_lin_properties (
   // Clock, reset and serial line.
   input wire logic        i_ref_clk,
   input wire logic        i_resetn,
   input wire logic        serial_in_line,
   input wire logic        serial_out_line,
   // Device strobes and status.
   input wire logic        i_ctl_wr,
   input wire logic        i_txbuf_wr,
   input wire logic [7:0]  o_ctl_status,
   input wire logic [15:0] o_divisor,
   input wire logic        o_receive_flag,
   input wire logic        o_transmit_flag,
   input wire logic        o_shift_empty
);
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (!i_resetn);
   // ------------------------------------------------------------
   // Transmit, calibration and wake relations.
   // ------------------------------------------------------------
   a_idle_line_high: assert property (o_shift_empty |-> serial_out_line)
      else $error("line low while shifter idle");
   a_tx_start_low: assert property (i_txbuf_wr && o_ctl_status[5] && o_transmit_flag && o_shift_empty
      |-> ##[1:3] !o_shift_empty && !serial_out_line) else $error("accepted write did not start");
   a_cal_idle_low: assert property (o_ctl_status[0] && $past(o_ctl_status[0]) |-> !o_ctl_status[7])
      else $error("receive idle set while calibrating");
   a_wake_idle_low: assert property (o_ctl_status[1] && $past(o_ctl_status[1]) |-> !o_ctl_status[7])
      else $error("receive idle set while wake armed");
   a_cal_done_flag: assert property ($fell(o_ctl_status[0]) && !$past(i_ctl_wr)
      |-> o_receive_flag && o_ctl_status[7]) else $error("calibration end without flag");
   a_wake_flag_set: assert property (o_ctl_status[1] && $fell(serial_in_line) |-> ##[1:3] o_receive_flag)
      else $error("wake fall without flag");
   a_wake_arm_clear: assert property (o_ctl_status[1] && $rose(serial_in_line) |-> ##[1:3] !o_ctl_status[1])
      else $error("wake arm kept after rise");
   a_cal_count_step: assert property (o_ctl_status[0] && $past(o_ctl_status[0]) |-> o_divisor == $past(o_divisor)
      || o_divisor == 16'($past(o_divisor) + 16'h0001) || o_divisor == 16'h0001) else $error("count jumped");
endmodule

/* File: uart_lin_autobaud_wake_break_tb.sv */
// Bench: device and remote node on one serial line.
`timescale 1ns/1ns
module uart_lin_autobaud_wake_break_tb;
   // ------------------------------------------------------------
   // Signals and counters.
   // ------------------------------------------------------------
   logic        i_ref_clk = 1'b0;
   logic        i_resetn  = 1'b0;
   logic        ctl_wr = 1'b0, div_wr = 1'b0, tx_wr = 1'b0, rx_rd = 1'b0;
   logic [15:0] wv = 16'h0000;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h00000000;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   wire         awready, wready, bvalid, arready, rvalid;
   wire  [1:0]  bresp, rresp;
   wire  [31:0] rdata;
   wire  [7:0]  o_ctl_status;
   wire  [15:0] o_divisor;
   wire         o_receive_flag, o_transmit_flag, o_shift_empty;
   int          err_count = 0, checks = 0;
   logic [31:0] rd_d, rd_r;
   logic [23:0] seen, busy;
   uart_lin_if link ();
   // 50 ns clock.
   always #25 i_ref_clk = ~i_ref_clk;
   uart_lin_dev u_uart_lin_dev (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_ctl_wr(ctl_wr), .i_ctl_wdata(wv[7:0]),
      .o_ctl_status(o_ctl_status), .i_div_wr(div_wr), .i_div_wdata(wv), .o_divisor(o_divisor), .i_rxbuf_rd(rx_rd),
      .o_receive_flag(o_receive_flag), .i_txbuf_wr(tx_wr), .i_txbuf_wdata(wv[7:0]), .o_transmit_flag(o_transmit_flag),
      .o_shift_empty(o_shift_empty), .line(link));
   uart_lin_node u_uart_lin_node (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_awaddr(awaddr), .i_awvalid(awvalid),
      .o_awready(awready), .i_wdata(wdata), .i_wstrb(4'hF), .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp),
      .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
      .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready), .line(link));
   uart_lin_properties u_props (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .serial_in_line(link.serial_in_line),
      .serial_out_line(link.serial_out_line), .i_ctl_wr(ctl_wr), .i_txbuf_wr(tx_wr), .o_ctl_status(o_ctl_status),
      .o_divisor(o_divisor), .o_receive_flag(o_receive_flag), .o_transmit_flag(o_transmit_flag),
      .o_shift_empty(o_shift_empty));
   // ------------------------------------------------------------
   // Access tasks and comparison.
   // ------------------------------------------------------------
   task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
      checks++;
      if (s !== e) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // One strobe for a single cycle: 0 control, 1 divisor, 2 transmit buffer, 3 receive buffer read.
   task automatic dev_wr(input int k, input logic [15:0] v);
      @(posedge i_ref_clk);
      {ctl_wr, div_wr, tx_wr, rx_rd} <= 4'(8 >> k);
      wv <= v;
      @(posedge i_ref_clk);
      {ctl_wr, div_wr, tx_wr, rx_rd} <= 4'h0;
      @(negedge i_ref_clk);
   endtask
   function automatic logic cond(input int s);
      case (s)
         0: cond = o_receive_flag;
         1: cond = !o_ctl_status[0];
         2: cond = !o_ctl_status[1];
         3: cond = o_transmit_flag;
         default: cond = !link.serial_out_line;
      endcase
   endfunction
   // Bounded wait: a stuck condition is reported, not hung on.
   task automatic wt(input int s);
      int n = 0;
      while (cond(s) !== 1'b1 && n < 40000) begin
         @(posedge i_ref_clk);
         n++;
      end
      if (n >= 40000) check("wait", 32'(s), 32'hFFFF);
   endtask
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      @(posedge i_ref_clk);
      awaddr <= a;
      wdata <= d;
      {awvalid, wvalid, bready} <= 3'h7;
      do begin
         @(posedge i_ref_clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      bready <= 1'b0;
      check("bresp", 32'(bresp), 32'(r));
   endtask
   task automatic axi_rd(input logic [7:0] a);
      @(posedge i_ref_clk);
      araddr <= a;
      {arvalid, rready} <= 2'h3;
      do begin
         @(posedge i_ref_clk);
         if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rready <= 1'b0;
      rd_d = rdata;
      rd_r = 32'(rresp);
   endtask
   // The node drops a command while one is pending, so wait for idle.
   task automatic send(input logic [31:0] c);
      rd_d = 32'h3;
      while (rd_d[1:0] !== 2'b00) axi_rd(uart_lin_pkg::REG_STATUS);
      axi_wr(uart_lin_pkg::REG_TX_CMD, c, uart_lin_pkg::RESP_OKAY);
   endtask
   // 55h sync at 320 clocks a bit: eight bits from first to fifth rise.
   task automatic cal(input logic [1:0] s, input logic w);
      int lo;
      lo = 2560 / ((s == 2'b00 ? 64 : s == 2'b11 ? 4 : 16) * 8) + 1;
      check("idle_pre", 32'(o_ctl_status[7]), 32'h1);
      dev_wr(0, {12'h000, s, w, 1'b1});
      if (w) begin
         send(32'h100);
         wt(0);
         dev_wr(3, 16'h0000);
         check("wake_rd", 32'(o_receive_flag), 32'h0);
         wt(2);
         check("arm_kept", 32'(o_ctl_status[0]), 32'h1);
      end
      send(32'h55);
      wt(1);
      check("cal_done", 32'({o_ctl_status[7], o_receive_flag}), 32'h3);
      check("cal_count", 32'(o_divisor >= lo && o_divisor <= lo + 1), 32'h1);
      dev_wr(3, 16'h0000);
      check("flag_clr", 32'(o_receive_flag), 32'h0);
   endtask
   // ------------------------------------------------------------
   // Main sequence.
   // ------------------------------------------------------------
   initial begin
      repeat (2) @(posedge i_ref_clk);
      i_resetn <= 1'b1;
      @(posedge i_ref_clk);
      check("status_rst", 32'(o_ctl_status), 32'h80);
      check("out_rst", 32'({o_divisor, o_receive_flag, o_transmit_flag, o_shift_empty}), 32'h3);
      axi_rd(uart_lin_pkg::REG_BIT_LEN);
      check("bitlen_rst", rd_d, 32'h64);
      axi_wr(uart_lin_pkg::REG_BIT_LEN, 32'h140, uart_lin_pkg::RESP_OKAY);
      axi_wr(8'h10, 32'h0, uart_lin_pkg::RESP_SLVERR);
      axi_rd(8'h0C);
      check("rresp", rd_r, 32'(uart_lin_pkg::RESP_SLVERR));
      for (int s = 0; s < 4; s++) cal(2'(s), 1'b0);
      cal(2'b11, 1'b1);
      dev_wr(1, 16'h0007);
      dev_wr(0, 16'h003C);
      dev_wr(2, 16'h00FF);
      fork
         begin
            wt(4);
            repeat (16) @(posedge i_ref_clk);
            for (int i = 0; i < 24; i++) begin
               seen[i] = link.serial_out_line;
               busy[i] = o_shift_empty;
               repeat (32) @(posedge i_ref_clk);
            end
         end
         begin
            wt(3);
            dev_wr(2, 16'h0055);
         end
      join
      check("break_line", 32'(seen), 32'({1'b1, 8'h55, 1'b0, 1'b1, 13'h0000}));
      check("break_busy", 32'(busy), 32'h0);
      repeat (40) @(posedge i_ref_clk);
      check("break_send_clr", 32'({o_shift_empty, o_ctl_status[4]}), 32'h2);
      print_verdict();
   end
   // Watchdog, well past the 21k cycles needed.
   initial begin
      #4000000;
      err_count++;
      print_verdict();
   end
endmodule
